// [core/isg_consts.vh]
// Constants for the instrument status group block
`ifndef ISG_CONSTS_VH
`define ISG_CONSTS_VH

// ==========================================================
// Command opcodes
`define ISG_OP_RD_COND 3'h0
`define ISG_OP_RD_EVENT 3'h1
`define ISG_OP_RD_ENABLE 3'h2
`define ISG_OP_WR_ENABLE 3'h3
`define ISG_OP_WR_PTR 3'h4
`define ISG_OP_WR_NTR 3'h5
`define ISG_OP_CLR_ALL 3'h6
`define ISG_OP_PRESET 3'h7

// ==========================================================
// Group selectors
`define ISG_GRP_QUAL 2'h0
`define ISG_GRP_OPER 2'h1
`define ISG_GRP_DEV 2'h2

// ==========================================================
// Measurement-quality bit positions
`define ISG_Q_POWER 3
`define ISG_Q_CAL 8
`define ISG_Q_SELFTEST 9

// ==========================================================
// Operation bit positions
`define ISG_O_CAL 0
`define ISG_O_ACQ 4
`define ISG_O_TRIG 5
`define ISG_O_SENSE 10
`define ISG_O_LOWER 11
`define ISG_O_UPPER 12

// ==========================================================
// Device bit positions
`define ISG_D_CONN_A 1
`define ISG_D_CONN_B 2
`define ISG_D_ERR_A 3
`define ISG_D_ERR_B 4
`define ISG_D_FR_A 5
`define ISG_D_FR_B 6
`define ISG_D_KEY 14

// ==========================================================
// Widths, masks and reset values
`define ISG_W 16
`define ISG_LIVE_MASK 16'h7fff
`define ISG_RST_ENABLE 16'h0000
`define ISG_RST_PTR 16'h7fff
`define ISG_RST_NTR 16'h0000
`define ISG_RST_WORD 16'h0000

`endif

// [core/isg_sync.v]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module isg_sync #(
  parameter W = 5
) (
  clk,
  rst_b,
  d_in,
  q_out
);
  input wire clk;
  input wire rst_b;
  input wire [W-1:0] d_in;
  output reg [W-1:0] q_out;

  reg [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

// [core/isg_group.v]
// One 16-bit status group: condition, filters, event, enable
`timescale 1ns/1ns
`include "isg_consts.vh"
module isg_group (
  clk,
  rst_b,
  cond_in,
  inject_in,
  wr_enable,
  wr_ptr,
  wr_ntr,
  wr_data,
  rd_clr,
  clr_all,
  preset,
  cond_out,
  event_out,
  enable_out,
  summary
);
  input wire clk;
  input wire rst_b;
  input wire [15:0] cond_in;
  input wire [15:0] inject_in;
  input wire wr_enable;
  input wire wr_ptr;
  input wire wr_ntr;
  input wire [15:0] wr_data;
  input wire rd_clr;
  input wire clr_all;
  input wire preset;
  output reg [15:0] cond_out;
  output reg [15:0] event_out;
  output reg [15:0] enable_out;
  output wire summary;

  reg [15:0] ptr_reg;
  reg [15:0] ntr_reg;
  reg [15:0] rise;
  reg [15:0] event_next;

  // ==========================================================
  // Transition filters and latched events
  always @* begin
    rise = ((cond_in & ~cond_out & ptr_reg) |
            (~cond_in & cond_out & ntr_reg)) & `ISG_LIVE_MASK;
    // Injected events bypass filters and the condition word
    rise = rise | (inject_in & `ISG_LIVE_MASK);
    event_next = event_out;
    if (rd_clr || clr_all) begin
      event_next = 16'h0000;
    end
    // New events win over a clear in the same cycle
    event_next = event_next | rise;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_out <= `ISG_RST_WORD;
      event_out <= `ISG_RST_WORD;
      enable_out <= `ISG_RST_ENABLE;
      ptr_reg <= `ISG_RST_PTR;
      ntr_reg <= `ISG_RST_NTR;
    end else begin
      cond_out <= cond_in & `ISG_LIVE_MASK;
      event_out <= event_next;
      if (wr_enable) begin
        enable_out <= wr_data & `ISG_LIVE_MASK;
      end
      if (wr_ptr) begin
        ptr_reg <= wr_data & `ISG_LIVE_MASK;
      end else if (preset) begin
        ptr_reg <= `ISG_RST_PTR;
      end
      if (wr_ntr) begin
        ntr_reg <= wr_data & `ISG_LIVE_MASK;
      end else if (preset) begin
        ntr_reg <= `ISG_RST_NTR;
      end
    end
  end

  assign summary = |(event_out & enable_out);
endmodule

// [core/isg_top.v]
// Status groups for quality, operation and device conditions
`timescale 1ns/1ns
`include "isg_consts.vh"
module isg_top #(
  parameter DUAL_CHANNEL = 1
) (
  clk,
  rst_b,
  cmd_valid,
  cmd_op,
  cmd_group,
  cmd_data,
  rsp_valid,
  rsp_data,
  rsp_err,
  qual_summary,
  oper_summary,
  dev_summary,
  pwr_stale,
  pwr_overload,
  pwr_need_zero,
  cal_end,
  cal_end_zero_err,
  cal_end_cal_err,
  selftest_done,
  selftest_pass,
  zero_start,
  calib_start,
  combined_start,
  acq_start,
  acq_end,
  lower_test_en,
  lower_test_fail,
  upper_test_en,
  upper_test_fail,
  trig_wait_enter,
  trig_idle_enter,
  sensor_mem_reading,
  sensor_mem_fail_a,
  sensor_mem_fail_b,
  front_present_a,
  rear_present_a,
  front_present_b,
  rear_present_b,
  key_press,
  acquisition_active
);
  input wire clk;
  input wire rst_b;
  input wire cmd_valid;
  input wire [2:0] cmd_op;
  input wire [1:0] cmd_group;
  input wire [15:0] cmd_data;
  output reg rsp_valid;
  output reg [15:0] rsp_data;
  output reg rsp_err;
  output reg qual_summary;
  output reg oper_summary;
  output reg dev_summary;
  input wire pwr_stale;
  input wire pwr_overload;
  input wire pwr_need_zero;
  input wire cal_end;
  input wire cal_end_zero_err;
  input wire cal_end_cal_err;
  input wire selftest_done;
  input wire selftest_pass;
  input wire zero_start;
  input wire calib_start;
  input wire combined_start;
  input wire acq_start;
  input wire acq_end;
  input wire lower_test_en;
  input wire lower_test_fail;
  input wire upper_test_en;
  input wire upper_test_fail;
  input wire trig_wait_enter;
  input wire trig_idle_enter;
  input wire sensor_mem_reading;
  input wire sensor_mem_fail_a;
  input wire sensor_mem_fail_b;
  input wire front_present_a;
  input wire rear_present_a;
  input wire front_present_b;
  input wire rear_present_b;
  input wire key_press;
  output reg acquisition_active;

  // ==========================================================
  // Pin synchronisation
  wire [4:0] pin_sync;
  reg key_prev_reg;
  wire key_pulse;

  isg_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d_in({key_press, rear_present_b, front_present_b,
           rear_present_a, front_present_a}),
    .q_out(pin_sync)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key_prev_reg <= 1'b0;
    end else begin
      key_prev_reg <= pin_sync[4];
    end
  end

  assign key_pulse = pin_sync[4] & ~key_prev_reg;

  // ==========================================================
  // Latched engine conditions
  reg cal_err_reg;
  reg selftest_fail_reg;
  reg calibrating_reg;
  reg lower_fail_reg;
  reg upper_fail_reg;
  reg trig_wait_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_err_reg <= 1'b0;
      selftest_fail_reg <= 1'b0;
      calibrating_reg <= 1'b0;
      acquisition_active <= 1'b0;
      lower_fail_reg <= 1'b0;
      upper_fail_reg <= 1'b0;
      trig_wait_reg <= 1'b0;
    end else begin
      if (cal_end) begin
        cal_err_reg <= cal_end_zero_err | cal_end_cal_err;
      end
      if (selftest_done) begin
        selftest_fail_reg <= ~selftest_pass;
      end
      // A start in the same cycle as an end keeps the bit set
      if (zero_start || calib_start || combined_start) begin
        calibrating_reg <= 1'b1;
      end else if (cal_end) begin
        calibrating_reg <= 1'b0;
      end
      if (acq_start) begin
        acquisition_active <= 1'b1;
      end else if (acq_end) begin
        acquisition_active <= 1'b0;
      end
      // Limit results are only judged at the end of a measurement
      if (acq_end) begin
        lower_fail_reg <= lower_test_en & lower_test_fail;
        upper_fail_reg <= upper_test_en & upper_test_fail;
      end
      if (trig_wait_enter) begin
        trig_wait_reg <= 1'b1;
      end else if (trig_idle_enter) begin
        trig_wait_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Condition words
  reg [15:0] qual_cond;
  reg [15:0] oper_cond;
  reg [15:0] dev_cond;
  reg [15:0] dev_inject;

  always @* begin
    qual_cond = 16'h0000;
    qual_cond[`ISG_Q_POWER] = pwr_stale | pwr_overload |
                              pwr_need_zero;
    qual_cond[`ISG_Q_CAL] = cal_err_reg;
    qual_cond[`ISG_Q_SELFTEST] = selftest_fail_reg;
    oper_cond = 16'h0000;
    oper_cond[`ISG_O_CAL] = calibrating_reg;
    oper_cond[`ISG_O_ACQ] = acquisition_active;
    oper_cond[`ISG_O_TRIG] = trig_wait_reg;
    oper_cond[`ISG_O_SENSE] = sensor_mem_reading;
    oper_cond[`ISG_O_LOWER] = lower_fail_reg;
    oper_cond[`ISG_O_UPPER] = upper_fail_reg;
    dev_cond = 16'h0000;
    dev_cond[`ISG_D_CONN_A] = pin_sync[0] | pin_sync[1];
    dev_cond[`ISG_D_ERR_A] = sensor_mem_fail_a |
                             (pin_sync[0] & pin_sync[1]);
    dev_cond[`ISG_D_FR_A] = pin_sync[1];
    if (DUAL_CHANNEL != 0) begin
      dev_cond[`ISG_D_CONN_B] = pin_sync[2] | pin_sync[3];
      dev_cond[`ISG_D_ERR_B] = sensor_mem_fail_b |
                               (pin_sync[2] & pin_sync[3]);
      dev_cond[`ISG_D_FR_B] = pin_sync[3];
    end
    dev_inject = 16'h0000;
    dev_inject[`ISG_D_KEY] = key_pulse;
  end

  // ==========================================================
  // Command decode
  function sel;
    input [1:0] g;
    input [1:0] want;
    begin
      sel = (g == want);
    end
  endfunction

  wire grp_q = cmd_valid & sel(cmd_group, `ISG_GRP_QUAL);
  wire grp_o = cmd_valid & sel(cmd_group, `ISG_GRP_OPER);
  wire grp_d = cmd_valid & sel(cmd_group, `ISG_GRP_DEV);
  wire is_rd_event = (cmd_op == `ISG_OP_RD_EVENT);
  wire is_wr_en = (cmd_op == `ISG_OP_WR_ENABLE);
  wire is_wr_ptr = (cmd_op == `ISG_OP_WR_PTR);
  wire is_wr_ntr = (cmd_op == `ISG_OP_WR_NTR);
  // Clear and preset act on every group whatever the selector
  wire is_clr = cmd_valid & (cmd_op == `ISG_OP_CLR_ALL);
  wire is_preset = cmd_valid & (cmd_op == `ISG_OP_PRESET);

  // ==========================================================
  // Status groups
  wire [15:0] q_cond;
  wire [15:0] q_event;
  wire [15:0] q_enable;
  wire q_sum;
  wire [15:0] o_cond;
  wire [15:0] o_event;
  wire [15:0] o_enable;
  wire o_sum;
  wire [15:0] d_cond;
  wire [15:0] d_event;
  wire [15:0] d_enable;
  wire d_sum;

  isg_group u_qual (
    .clk(clk),
    .rst_b(rst_b),
    .cond_in(qual_cond),
    .inject_in(16'h0000),
    .wr_enable(grp_q & is_wr_en),
    .wr_ptr(grp_q & is_wr_ptr),
    .wr_ntr(grp_q & is_wr_ntr),
    .wr_data(cmd_data),
    .rd_clr(grp_q & is_rd_event),
    .clr_all(is_clr),
    .preset(is_preset),
    .cond_out(q_cond),
    .event_out(q_event),
    .enable_out(q_enable),
    .summary(q_sum)
  );

  isg_group u_oper (
    .clk(clk),
    .rst_b(rst_b),
    .cond_in(oper_cond),
    .inject_in(16'h0000),
    .wr_enable(grp_o & is_wr_en),
    .wr_ptr(grp_o & is_wr_ptr),
    .wr_ntr(grp_o & is_wr_ntr),
    .wr_data(cmd_data),
    .rd_clr(grp_o & is_rd_event),
    .clr_all(is_clr),
    .preset(is_preset),
    .cond_out(o_cond),
    .event_out(o_event),
    .enable_out(o_enable),
    .summary(o_sum)
  );

  isg_group u_dev (
    .clk(clk),
    .rst_b(rst_b),
    .cond_in(dev_cond),
    .inject_in(dev_inject),
    .wr_enable(grp_d & is_wr_en),
    .wr_ptr(grp_d & is_wr_ptr),
    .wr_ntr(grp_d & is_wr_ntr),
    .wr_data(cmd_data),
    .rd_clr(grp_d & is_rd_event),
    .clr_all(is_clr),
    .preset(is_preset),
    .cond_out(d_cond),
    .event_out(d_event),
    .enable_out(d_enable),
    .summary(d_sum)
  );

  // ==========================================================
  // Response and summaries
  function [15:0] pick;
    input [2:0] op;
    input [15:0] c;
    input [15:0] e;
    input [15:0] n;
    begin
      case (op)
        `ISG_OP_RD_COND: pick = c;
        `ISG_OP_RD_EVENT: pick = e;
        `ISG_OP_RD_ENABLE: pick = n;
        default: pick = 16'h0000;
      endcase
    end
  endfunction

  reg [15:0] rsp_next;
  reg err_next;

  always @* begin
    rsp_next = 16'h0000;
    err_next = 1'b0;
    case (cmd_group)
      `ISG_GRP_QUAL: rsp_next = pick(cmd_op, q_cond, q_event, q_enable);
      `ISG_GRP_OPER: rsp_next = pick(cmd_op, o_cond, o_event, o_enable);
      `ISG_GRP_DEV: rsp_next = pick(cmd_op, d_cond, d_event, d_enable);
      default: begin
        // Unmapped group only matters for per-group commands
        err_next = ~(is_clr | is_preset);
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_err <= 1'b0;
      qual_summary <= 1'b0;
      oper_summary <= 1'b0;
      dev_summary <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
      if (cmd_valid) begin
        rsp_data <= rsp_next & `ISG_LIVE_MASK;
        rsp_err <= err_next;
      end
      qual_summary <= q_sum;
      oper_summary <= o_sum;
      dev_summary <= d_sum;
    end
  end
endmodule

// [dv/isg_checker.sv]
// Port assertions for the status group block
`timescale 1ns/1ns
`include "isg_consts.vh"
module isg_checker (
  input wire clk,
  input wire rst_b,
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [1:0] cmd_group,
  input wire [15:0] cmd_data,
  input wire rsp_valid,
  input wire [15:0] rsp_data,
  input wire rsp_err,
  input wire qual_summary,
  input wire oper_summary,
  input wire acq_start,
  input wire acq_end,
  input wire acquisition_active
);
  // ==========================================================
  // Command channel and status outputs
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire wr_off = cmd_valid && cmd_op == `ISG_OP_WR_ENABLE && cmd_data == 16'h0;
  a_rsp_follows_cmd: assert property (cmd_valid |=> rsp_valid)
    else $error("no response");
  a_rsp_needs_cmd: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("response without command");
  a_msb_stays_zero: assert property (rsp_valid |-> !rsp_data[15])
    else $error("bit 15 set");
  a_bad_group_err: assert property (
    cmd_valid && cmd_group == 2'h3 && cmd_op < 3'h6
    |=> rsp_err && rsp_data == 16'h0)
    else $error("bad group accepted");
  a_good_group_ok: assert property (
    cmd_valid && cmd_group != 2'h3 |=> !rsp_err)
    else $error("good group refused");
  a_acq_rise: assert property (
    acq_start && !acq_end |-> ##[1:2] acquisition_active)
    else $error("measurement not active");
  a_acq_fall: assert property (
    acq_end && !acq_start |-> ##[1:2] !acquisition_active)
    else $error("measurement still active");
  a_qual_mask_off: assert property (
    wr_off && cmd_group == `ISG_GRP_QUAL |-> ##2 !qual_summary)
    else $error("quality summary despite mask");
  a_oper_mask_off: assert property (
    wr_off && cmd_group == `ISG_GRP_OPER |-> ##2 !oper_summary)
    else $error("operation summary despite mask");
  c_refused: cover property (cmd_valid && cmd_group == 2'h3);
  c_qual_sum: cover property (qual_summary);
  c_measure: cover property ($rose(acquisition_active));
endmodule

bind isg_top isg_checker u_chk (.clk, .rst_b, .cmd_valid, .cmd_op, .cmd_group,
  .cmd_data, .rsp_valid, .rsp_data, .rsp_err, .qual_summary, .oper_summary,
  .acq_start, .acq_end, .acquisition_active);

// [dv/isg_host_model.sv]
// Remote controller model issuing status commands
`timescale 1ns/1ns
module isg_host_model (
  input wire clk,
  output reg cmd_valid,
  output reg [2:0] cmd_op,
  output reg [1:0] cmd_group,
  output reg [15:0] cmd_data,
  input wire rsp_valid,
  input wire [15:0] rsp_data,
  input wire rsp_err
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_group = 2'h0;
    cmd_data = 16'h0;
  end
  // Gap cycles model a slow controller; one command in flight at a time
  task xfer(input [2:0] op, input [1:0] g, input [15:0] d,
    input integer gap, output [15:0] q, output e, output ok);
    integer i;
    begin
      ok = 1'b0;
      q = 16'h0;
      e = 1'b0;
      repeat (gap + 1) @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_group = g;
      cmd_data = d;
      for (i = 0; i < 3 && !ok; i = i + 1) begin
        @(negedge clk);
        cmd_valid = 1'b0;
        // Stale write data must never be relied on
        cmd_data = ~d;
        if (rsp_valid === 1'b1) begin
          ok = 1'b1;
          q = rsp_data;
          e = rsp_err;
        end
      end
    end
  endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the status group block
`timescale 1ns/1ns
`include "isg_consts.vh"
module tb;
  localparam [2:0] RC = `ISG_OP_RD_COND;
  localparam [2:0] RE = `ISG_OP_RD_EVENT;
  localparam [2:0] WE = `ISG_OP_WR_ENABLE;
  localparam [1:0] GQ = `ISG_GRP_QUAL;
  localparam [1:0] GO = `ISG_GRP_OPER;
  localparam [1:0] GD = `ISG_GRP_DEV;
  localparam P_CAL = 0, P_ST = 1, P_ZERO = 2, P_ACQ = 5, P_ACQE = 6;
  localparam P_TW = 7, P_TI = 8;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [8:0] pls = 9'h0;
  reg pwr_stale = 1'b0, pwr_overload = 1'b0, pwr_need_zero = 1'b0;
  reg cal_end_zero_err = 1'b0, cal_end_cal_err = 1'b0, selftest_pass = 1'b0;
  reg lower_test_en = 1'b0, lower_test_fail = 1'b0, upper_test_en = 1'b0;
  reg upper_test_fail = 1'b0, sensor_mem_reading = 1'b0, key_press = 1'b0;
  reg sensor_mem_fail_a = 1'b0, sensor_mem_fail_b = 1'b0;
  reg front_present_a = 1'b0, rear_present_a = 1'b0;
  reg front_present_b = 1'b0, rear_present_b = 1'b0;
  wire cal_end, selftest_done, zero_start, calib_start, combined_start;
  wire acq_start, acq_end, trig_wait_enter, trig_idle_enter;
  wire cmd_valid, rsp_valid, rsp_err, qual_summary, oper_summary;
  wire dev_summary, acquisition_active;
  wire [2:0] cmd_op;
  wire [1:0] cmd_group;
  wire [15:0] cmd_data, rsp_data;
  integer n_fail = 0;
  integer checked = 0;
  integer k;
  reg [15:0] q, x;
  reg [3:0] p;
  reg [1:0] mf;
  reg e, ok;
  // Model of the three enable masks, written only through commands
  reg [15:0] m_en [0:2] = '{16'h0, 16'h0, 16'h0};
  assign {trig_idle_enter, trig_wait_enter, acq_end, acq_start} = pls[8:5];
  assign {combined_start, calib_start, zero_start} = pls[4:2];
  assign {selftest_done, cal_end} = pls[1:0];
  isg_top #(.DUAL_CHANNEL(1)) DUT (.*);
  isg_host_model host (.*);
  always #25 clk = ~clk;
  // ==========================================================
  // Shared tasks
  task chk(input [8*12:1] what, input [15:0] exp, input [15:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected %0s: expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task cmd(input [2:0] op, input [1:0] g, input [15:0] d);
    begin
      host.xfer(op, g, d, $urandom % 3, q, e, ok);
      chk("answer", 16'h1, {15'h0, ok});
      chk("error", {15'h0, g == 2'h3 && op < 3'h6}, {15'h0, e});
      if (g != 2'h3 && op == WE)
        m_en[g] = d & 16'h7fff;
      if (g != 2'h3 && op == `ISG_OP_RD_ENABLE)
        chk("enable", m_en[g], q);
    end
  endtask
  task pulse(input integer b);
    begin
      @(negedge clk);
      pls[b] = 1'b1;
      @(negedge clk);
      pls = 9'h0;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #(50 * 20000);
    n_fail = n_fail + 1;
    test_done;
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h34d6));
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    for (k = 0; k < 9; k = k + 1) begin
      cmd(3'(k % 3), 2'(k / 3), 16'h0);
      chk("reset word", 16'h0, q);
    end
    for (k = 0; k < 6; k = k + 1) begin
      cmd(3'(k), 2'h3, 16'h7fff);
      chk("refused", 16'h0, q | {15'h0, ~e});
    end
    k = $urandom % 3;
    {pwr_need_zero, pwr_overload, pwr_stale} = 3'b001 << k;
    repeat (4) @(negedge clk);
    cmd(RC, GQ, 16'h0);
    chk("qual cond", 16'h8, q);
    cmd(WE, GQ, 16'h8);
    repeat (3) @(negedge clk);
    chk("qual sum", 16'h1, {15'h0, qual_summary});
    cmd(WE, GQ, 16'h0);
    repeat (3) @(negedge clk);
    chk("qual sum", 16'h0, {15'h0, qual_summary});
    cmd(RE, GQ, 16'h0);
    chk("qual event", 16'h8, q);
    cmd(RE, GQ, 16'h0);
    chk("qual event", 16'h0, q);
    cmd(`ISG_OP_WR_PTR, GQ, 16'h0);
    cmd(`ISG_OP_WR_NTR, GQ, 16'h8);
    {pwr_need_zero, pwr_overload, pwr_stale} = 3'b000;
    repeat (4) @(negedge clk);
    cmd(RE, GQ, 16'h0);
    chk("fall event", 16'h8, q);
    cmd(`ISG_OP_PRESET, GQ, 16'h0);
    pwr_overload = 1'b1;
    repeat (4) @(negedge clk);
    cmd(`ISG_OP_CLR_ALL, GQ, 16'h0);
    cmd(RE, GQ, 16'h0);
    chk("clr event", 16'h0, q);
    for (k = 0; k < 4; k = k + 1) begin
      {cal_end_cal_err, cal_end_zero_err} = 2'(k);
      selftest_pass = 1'($urandom);
      pulse(P_CAL);
      pulse(P_ST);
      repeat (3) @(negedge clk);
      cmd(RC, GQ, 16'h0);
      x = {6'h0, ~selftest_pass, k != 0, 8'h08};
      chk("qual cond", x, q);
    end
    {cal_end_cal_err, cal_end_zero_err} = 2'b00;
    cmd(WE, GO, 16'h0);
    for (k = 0; k < 3; k = k + 1) begin
      pulse(P_ZERO + k);
      repeat (3) @(negedge clk);
      cmd(RC, GO, 16'h0);
      chk("calibrating", 16'h1, q & 16'h1);
      pulse(P_CAL);
      repeat (3) @(negedge clk);
      cmd(RC, GO, 16'h0);
      chk("calibrating", 16'h0, q & 16'h1);
    end
    cmd(WE, GO, 16'h1);
    repeat (3) @(negedge clk);
    chk("oper sum", 16'h1, {15'h0, oper_summary});
    cmd(`ISG_OP_RD_ENABLE, GO, 16'h0);
    for (k = 0; k < 8; k = k + 1) begin
      p = 4'($urandom);
      {lower_test_en, lower_test_fail, upper_test_en, upper_test_fail} = p;
      pulse(P_ACQ);
      @(negedge clk);
      chk("active", 16'h1, {15'h0, acquisition_active});
      repeat (k) @(negedge clk);
      pulse(P_ACQE);
      repeat (3) @(negedge clk);
      cmd(RC, GO, 16'h0);
      x = {3'h0, &p[1:0], &p[3:2], 11'h0};
      chk("limits", x, q & 16'h1810);
    end
    pulse(P_TW);
    sensor_mem_reading = 1'b1;
    repeat (3) @(negedge clk);
    cmd(RC, GO, 16'h0);
    chk("trig sense", 16'h0420, q & 16'h0420);
    pulse(P_TI);
    sensor_mem_reading = 1'b0;
    repeat (3) @(negedge clk);
    cmd(RC, GO, 16'h0);
    chk("trig sense", 16'h0, q & 16'h0420);
    for (k = 0; k < 16; k = k + 1) begin
      p = 4'(k);
      mf = 2'($urandom);
      {rear_present_b, front_present_b, rear_present_a, front_present_a} = p;
      {sensor_mem_fail_b, sensor_mem_fail_a} = mf;
      repeat (5) @(negedge clk);
      cmd(RC, GD, 16'h0);
      x = {9'h0, p[3], p[1], mf[1] | &p[3:2], mf[0] | &p[1:0],
        |p[3:2], |p[1:0], 1'b0};
      chk("dev cond", x, q);
    end
    cmd(RE, GD, 16'h0);
    cmd(WE, GD, 16'h4000);
    key_press = 1'b1;
    repeat (3) @(negedge clk);
    key_press = 1'b0;
    repeat (6) @(negedge clk);
    chk("dev sum", 16'h1, {15'h0, dev_summary});
    cmd(RC, GD, 16'h0);
    chk("key cond", 16'h0, q & 16'h4000);
    cmd(RE, GD, 16'h0);
    chk("key event", 16'h4000, q);
    cmd(RE, GD, 16'h0);
    chk("key event", 16'h0, q);
    cmd(`ISG_OP_RD_ENABLE, GD, 16'h0);
    test_done;
  end
endmodule
